// ### logic/dyas_pkg.sv
// Constants, register map and carrier types of the dynamometer alarm supervisor.
package dyas_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIM0 = 8'h04;
  localparam logic [7:0] REG_LIM1 = 8'h08;
  localparam logic [7:0] REG_GLIM = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_LIMSEL = 8'h14;
  localparam int CTRL_ALARM_EN = 0;
  localparam int CTRL_AIR_EN = 1;
  localparam int CTRL_WATER_EN = 2;
  localparam int CTRL_EXT_EN = 3;
  localparam int CTRL_CLUTCH_EN = 4;
  localparam int CTRL_TANDEM = 5;
  localparam int CTRL_TYPE_LO = 6;
  localparam int STAT_MSG_LO = 12;
  localparam int STAT_OL_LO = 16;
  localparam int STAT_SEL = 18;
  localparam int STAT_STBY = 19;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [15:0] LIMIT_RESET = 16'h0001;
  localparam logic [15:0] GLIMIT_RESET = 16'hFFFF;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int MS_W = 13;
  localparam logic [MS_W-1:0] PERSIST_MS = 13'h1388;
  localparam logic [MS_W-1:0] HOLD_MS = 13'h0BB8;
  localparam logic [MS_W-1:0] STBY_MS = 13'h03E8;
  localparam logic [MS_W-1:0] CLUTCH_MS = 13'h0064;
  typedef enum logic [1:0] {
    BRK_HYST = 2'h0,
    BRK_EDDY = 2'h1,
    BRK_POWDER = 2'h2
  } dyas_brake_t;
  typedef enum logic [3:0] {
    MSG_NONE = 4'h0,
    MSG_TEMP = 4'h1,
    MSG_ELEC = 4'h2,
    MSG_EXT = 4'h3,
    MSG_AIR = 4'h4,
    MSG_WATER = 4'h5,
    MSG_CLUTCH = 4'h6,
    MSG_TORQUE = 4'h7,
    MSG_GLOBAL = 4'hA
  } dyas_msg_t;
  typedef enum logic [1:0] {
    CL_IDLE = 2'h0,
    CL_TOG1 = 2'h1,
    CL_TOG2 = 2'h3,
    CL_FAIL = 2'h2
  } dyas_clutch_t;
  typedef struct packed {
    logic temp;
    logic elec;
    logic ext;
    logic air;
    logic water;
    logic clutch;
    logic glob;
    logic [1:0] tq;
  } dyas_alarm_t;
endpackage : dyas_pkg

// ### logic/dyas_supervisor.sv
// Alarm supervisor: limit checks, alarm latches, excitation override and APB registers.
// Behaviour
// - Torque above limit, under 120%: overload flag.
// - Over 120% or overload over 5 s: alarm.
// - Torque alarm: relay open, hold 3 s, zero.
// - Tandem over global limit: same torque action.
// - Global alarm only in eddy/powder tandem.
// - Air flow: hysteresis only, off default, brake on.
// - Air flow loss: relay open, excitation 10%.
// - Water flow loss on eddy/powder: relay, 10%.
// - External input low when enabled: relay, 10%.
// - Overheat: relay, 10% now, zero after 3 s.
// - Temperature/electrical always on, eddy/powder only.
// - Electrical overload: relay open, excitation zero now.
// - Standby pulses one second after their reset.
// - Clutch open at zero speed: toggle twice, alarm.
// - Clutch alarm shows clutch failure message.
// - Non-shift key clears alarm once condition gone.
// - Temperature/electrical/clutch stay until condition clears.
// - Torque limit defaults to one, per channel.
// - Two channel limits, channel key selects.
// - Display shows highest-priority active alarm only.
// - Enabled alarms are watched on both channels.
`timescale 1ns/100ps
`default_nettype none
module dyas_supervisor
  import dyas_pkg::*;
#(
  parameter int TW = 16,
  parameter int EW = 16,
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TW-1:0] torque0,
  input wire logic [TW-1:0] torque1,
  input wire logic brake_on,
  input wire logic air_flow_ok,
  input wire logic water_flow_ok,
  input wire logic ext_tied,
  input wire logic thermal_ok,
  input wire logic elec_overload,
  input wire logic clutch_closed,
  input wire logic speed_zero,
  input wire logic clutch_cmd,
  input wire logic key_press,
  input wire logic key_shift,
  input wire logic channel_select_key,
  input wire logic [EW-1:0] exc_cmd_in,
  output logic relay_closed,
  output logic [EW-1:0] exc_cmd_out,
  output logic standby,
  output logic clutch_ctrl,
  output logic [1:0] overload_indication,
  output dyas_msg_t alarm_msg,
  output logic msg_channel
);
  generate
    if (TW < 2 || TW > 16 || EW < 4 || TICK_CYCLES < 1 || TICK_CYCLES > 262143) begin : g_bad
      $error("dyas_supervisor: unsupported parameter values");
    end
  endgenerate

  function automatic logic [EW-1:0] pct10(input logic [EW-1:0] v);
    pct10 = v / EW'(10);
  endfunction : pct10

  function automatic logic over120(input logic [TW-1:0] t, input logic [TW:0] lim);
    over120 = ({3'h0, t} * (TW+4)'(5)) > ({3'h0, lim} * (TW+4)'(6));
  endfunction : over120

  logic [7:0] ctrl;
  logic [TW-1:0] limit [2];
  logic [TW:0] glimit;
  logic sel_ch;
  dyas_alarm_t alarm;
  logic [17:0] tick_cnt;
  logic [MS_W-1:0] persist [2];
  logic [MS_W-1:0] alarm_ms;
  logic [MS_W-1:0] stby_ms;
  logic [MS_W-1:0] cl_ms;
  dyas_clutch_t cl_state;
  logic cl_flip;
  logic [EW-1:0] exc_last;

  wire tick = (tick_cnt == 18'(TICK_CYCLES - 1));
  wire dyas_brake_t brake_type = dyas_brake_t'(ctrl[CTRL_TYPE_LO +: 2]);
  wire wp_brake = (brake_type == BRK_EDDY) || (brake_type == BRK_POWDER);
  wire alarms_on = ctrl[CTRL_ALARM_EN];
  wire tandem = ctrl[CTRL_TANDEM];
  wire key_clear = key_press && !key_shift;
  wire [TW-1:0] torque [2];
  assign torque[0] = torque0;
  assign torque[1] = torque1;
  wire [TW:0] tandem_sum = {1'b0, torque0} + {1'b0, torque1};

  logic [1:0] over;
  logic [1:0] hard;
  logic [1:0] tq_cond;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      over[c] = torque[c] > limit[c];
      hard[c] = over120(torque[c], {1'b0, limit[c]});
      tq_cond[c] = alarms_on && (hard[c] || (over[c] && persist[c] >= PERSIST_MS));
    end
  end

  wire glob_mode = tandem && wp_brake;
  wire glob_cond = alarms_on && glob_mode && (tandem_sum > glimit);
  wire air_cond = alarms_on && ctrl[CTRL_AIR_EN] && brake_type == BRK_HYST
      && brake_on && !air_flow_ok;
  wire water_cond = alarms_on && ctrl[CTRL_WATER_EN] && wp_brake
      && brake_on && !water_flow_ok;
  wire ext_cond = alarms_on && ctrl[CTRL_EXT_EN] && !ext_tied;
  wire temp_cond = wp_brake && !thermal_ok;
  wire elec_cond = wp_brake && elec_overload;
  wire clutch_cond = (cl_state == CL_FAIL) && !clutch_closed;

  dyas_alarm_t cond;
  assign cond = '{temp: temp_cond, elec: elec_cond, ext: ext_cond, air: air_cond,
      water: water_cond, clutch: clutch_cond, glob: glob_cond, tq: tq_cond};

  // A present condition re-sets its latch in the same cycle, so a key never loses it.
  dyas_alarm_t next_alarm;
  assign next_alarm = cond | (key_clear ? '0 : alarm);
  wire any_alarm = |alarm;

  wire clutch_mode = ctrl[CTRL_CLUTCH_EN] && tandem && wp_brake;
  dyas_clutch_t next_cl;
  always_comb begin
    next_cl = cl_state;
    case (cl_state)
      CL_IDLE: if (clutch_mode && speed_zero && !clutch_closed) next_cl = CL_TOG1;
      CL_TOG1: if (tick && cl_ms >= CLUTCH_MS) next_cl = CL_TOG2;
      CL_TOG2: if (tick && cl_ms >= CLUTCH_MS) next_cl = clutch_closed ? CL_IDLE : CL_FAIL;
      CL_FAIL: if (!alarm.clutch && !clutch_cond) next_cl = CL_IDLE;
      default: next_cl = CL_IDLE;
    endcase
  end

  logic [EW-1:0] next_exc;
  wire hold_done = alarm_ms >= HOLD_MS;
  always_comb begin
    if (alarm.elec) next_exc = '0;
    else if (alarm.temp) next_exc = hold_done ? '0 : pct10(exc_last);
    else if (alarm.ext || alarm.air || alarm.water) next_exc = pct10(exc_last);
    else if (alarm.glob || |alarm.tq) next_exc = hold_done ? '0 : exc_last;
    else if (alarm.clutch) next_exc = exc_last;
    else next_exc = exc_cmd_in;
  end

  dyas_msg_t next_msg;
  logic next_msg_ch;
  always_comb begin
    next_msg_ch = 1'b0;
    if (alarm.temp) next_msg = MSG_TEMP;
    else if (alarm.elec) next_msg = MSG_ELEC;
    else if (alarm.ext) next_msg = MSG_EXT;
    else if (alarm.air) next_msg = MSG_AIR;
    else if (alarm.water) next_msg = MSG_WATER;
    else if (alarm.clutch) next_msg = MSG_CLUTCH;
    else if (|alarm.tq) begin
      next_msg = MSG_TORQUE;
      next_msg_ch = !alarm.tq[0];
    end else if (alarm.glob) next_msg = MSG_GLOBAL;
    else next_msg = MSG_NONE;
  end

  wire stby_start = (alarm.temp && !next_alarm.temp) || (alarm.elec && !next_alarm.elec);

  // APB: pready rises one cycle into the access phase; the write lands on the completing edge.
  wire acc = psel && penable;
  wire done = acc && pready;
  wire hit_ctrl = paddr == REG_CTRL;
  wire hit_lim0 = paddr == REG_LIM0 || (paddr == REG_LIMSEL && !sel_ch);
  wire hit_lim1 = paddr == REG_LIM1 || (paddr == REG_LIMSEL && sel_ch);
  wire hit_glim = paddr == REG_GLIM;
  wire mapped = hit_ctrl || hit_lim0 || hit_lim1 || hit_glim || paddr == REG_STAT;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) rd_mux[7:0] = ctrl;
    else if (hit_lim0) rd_mux[TW-1:0] = limit[0];
    else if (hit_lim1) rd_mux[TW-1:0] = limit[1];
    else if (hit_glim) rd_mux[TW:0] = glimit;
    else if (paddr == REG_STAT) begin
      rd_mux[$bits(dyas_alarm_t)-1:0] = alarm;
      rd_mux[STAT_MSG_LO +: 4] = alarm_msg;
      rd_mux[STAT_OL_LO +: 2] = overload_indication;
      rd_mux[STAT_SEL] = sel_ch;
      rd_mux[STAT_STBY] = standby;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (pclken) begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      prdata <= (acc && !pready && !pwrite) ? rd_mux : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      limit[0] <= TW'(LIMIT_RESET);
      limit[1] <= TW'(LIMIT_RESET);
      glimit <= (TW+1)'(GLIMIT_RESET);
      sel_ch <= 1'b0;
    end else if (pclken) begin
      if (channel_select_key) sel_ch <= !sel_ch;
      if (done && pwrite && hit_ctrl) ctrl <= pwdata[7:0];
      if (done && pwrite && hit_lim0) limit[0] <= pwdata[TW-1:0];
      if (done && pwrite && hit_lim1) limit[1] <= pwdata[TW-1:0];
      if (done && pwrite && hit_glim) glimit <= pwdata[TW:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      persist[0] <= '0;
      persist[1] <= '0;
      alarm_ms <= '0;
      stby_ms <= '0;
    end else if (pclken) begin
      tick_cnt <= tick ? '0 : tick_cnt + 18'h00001;
      for (int c = 0; c < 2; c++) begin
        if (!over[c]) persist[c] <= '0;
        else if (tick && persist[c] != PERSIST_MS) persist[c] <= persist[c] + 13'h0001;
      end
      if (!any_alarm) alarm_ms <= '0;
      else if (tick && !hold_done) alarm_ms <= alarm_ms + 13'h0001;
      if (stby_start) stby_ms <= STBY_MS;
      else if (tick && stby_ms != '0) stby_ms <= stby_ms - 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_state <= CL_IDLE;
      cl_ms <= '0;
      cl_flip <= 1'b0;
    end else if (pclken) begin
      cl_state <= next_cl;
      cl_ms <= (next_cl != cl_state) ? '0 : (tick ? cl_ms + 13'h0001 : cl_ms);
      if (next_cl != cl_state && (next_cl == CL_TOG1 || next_cl == CL_TOG2)) begin
        cl_flip <= !cl_flip;
      end else if (next_cl != cl_state && cl_state == CL_TOG2) begin
        cl_flip <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm <= '0;
      exc_last <= '0;
      relay_closed <= 1'b0;
      exc_cmd_out <= '0;
      standby <= 1'b0;
      clutch_ctrl <= 1'b0;
      overload_indication <= '0;
      alarm_msg <= MSG_NONE;
      msg_channel <= 1'b0;
    end else if (pclken) begin
      alarm <= next_alarm;
      if (!any_alarm) exc_last <= exc_cmd_in;
      relay_closed <= ~|next_alarm;
      exc_cmd_out <= next_exc;
      standby <= stby_start || stby_ms > 13'h0001;
      clutch_ctrl <= clutch_cmd ^ cl_flip;
      overload_indication <= over & ~hard;
      alarm_msg <= next_msg;
      msg_channel <= next_msg_ch;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_relay_open: assert property (any_alarm |-> !relay_closed)
    else $error("relay closed while an alarm is latched");
  a_elec_zero: assert property (alarm.elec |-> next_exc == '0)
    else $error("electrical alarm did not zero excitation");
  a_air_reduce: assert property (alarm == '{air: 1'b1, default: 1'b0}
      |-> next_exc == pct10(exc_last))
    else $error("air flow alarm did not reduce excitation to a tenth");
  a_torque_hold: assert property (alarm.tq != 2'h0 && (alarm & ~9'h003) == '0
      |-> next_exc == (alarm_ms >= HOLD_MS ? '0 : exc_last))
    else $error("torque alarm excitation hold wrong");
  a_temp_zero: assert property (alarm.temp && !alarm.elec && alarm_ms >= HOLD_MS
      |-> next_exc == '0)
    else $error("overheat did not zero excitation after hold");
  a_global_mode: assert property (!glob_mode |-> !glob_cond)
    else $error("global torque checked outside tandem");
  a_air_gate: assert property (air_cond |-> brake_on && brake_type == BRK_HYST
      && ctrl[CTRL_AIR_EN])
    else $error("air flow checked when not allowed");
  a_hard_torque: assert property (pclken && alarms_on && hard[0] |=> alarm.tq[0])
    else $error("over 120 percent torque did not alarm");
  a_clear_refused: assert property (pclken && alarm.temp && temp_cond |=> alarm.temp)
    else $error("temperature alarm cleared with condition present");
  a_standby_pulse: assert property (pclken && stby_start |=> standby)
    else $error("standby pulse missing after reset");
  a_prio_temp: assert property (pclken && alarm.temp |=> alarm_msg == MSG_TEMP)
    else $error("temperature alarm not shown first");
  a_clutch_msg: assert property (pclken && alarm.clutch && (alarm & 9'h1F0) == '0
      |=> alarm_msg == MSG_CLUTCH)
    else $error("clutch failure message missing");

  c_torque_alarm: cover property (pclken && $rose(alarm.tq[0]));
  c_standby: cover property (pclken && stby_start);
  c_clutch_fail: cover property (cl_state == CL_FAIL && alarm.clutch);
  c_hold_zero: cover property (alarm.tq[1] && hold_done);
endmodule : dyas_supervisor
`default_nettype wire

// ### test/dyas_far_side.sv
// Far-side model: brake sensors and front-panel keypad of the alarm supervisor.
`timescale 1ns/100ps
`default_nettype none
module dyas_far_side (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] fault,
  input wire logic key_req,
  input wire logic shift_req,
  output logic air_flow_ok,
  output logic water_flow_ok,
  output logic ext_tied,
  output logic thermal_ok,
  output logic elec_overload,
  output logic key_press,
  output logic key_shift
);
  // Sensors pass a register, as a real input filter adds a cycle of delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {air_flow_ok, water_flow_ok, ext_tied, thermal_ok, elec_overload} <= 5'h1E;
      key_press <= 1'b0;
      key_shift <= 1'b0;
    end else begin
      air_flow_ok <= !fault[0];
      water_flow_ok <= !fault[1];
      ext_tied <= !fault[2];
      thermal_ok <= !fault[3];
      elec_overload <= fault[4];
      key_press <= key_req;
      key_shift <= shift_req;
    end
  end
endmodule : dyas_far_side
`default_nettype wire

// ### test/dyas_supervisor_tb.sv
// Self-checking testbench of the dynamometer alarm supervisor.
`timescale 1ns/100ps
`default_nettype none
module dyas_supervisor_tb;
  import dyas_pkg::*;
  localparam int TK = 2;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] torque0 = 16'h0, torque1 = 16'h0, exc_in = 16'h03E8;
  logic [4:0] fault = 5'h00;
  logic key_req = 0, shift_req = 0, brake_on = 1, clutch_closed = 1;
  logic speed_zero = 0, clutch_cmd = 0, channel_select_key = 0, pclken = 1;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, air_flow_ok, water_flow_ok, ext_tied, thermal_ok;
  wire logic elec_overload, key_press, key_shift, relay_closed, standby, msg_channel;
  wire logic clutch_ctrl;
  wire logic [15:0] exc_cmd_out;
  wire logic [1:0] overload_indication;
  dyas_msg_t alarm_msg;
  integer fail_count = 0, checks = 0, seed = 12;
  logic [32:0] exp_q[$];
  always #2.5 pclk = ~pclk;
  dyas_far_side far_u (.pclk, .presetn, .fault, .key_req, .shift_req, .air_flow_ok,
    .water_flow_ok, .ext_tied, .thermal_ok, .elec_overload, .key_press, .key_shift);
  dyas_supervisor #(.TICK_CYCLES(TK)) dut_u (.pclk, .presetn, .pclken, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .torque0, .torque1,
    .brake_on, .air_flow_ok, .water_flow_ok, .ext_tied, .thermal_ok, .elec_overload,
    .clutch_closed, .speed_zero, .clutch_cmd, .key_press, .key_shift,
    .channel_select_key, .exc_cmd_in(exc_in), .relay_closed, .exc_cmd_out, .standby,
    .clutch_ctrl, .overload_indication, .alarm_msg, .msg_channel);
  task chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  // Read expectations hold pslverr above the 32 data bits.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int i;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      fail_count++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wrel(input logic v);
    int i;
    i = 0;
    do begin
      @(negedge pclk);
      i++;
    end while (relay_closed !== v && i < 400);
    if (i >= 400) begin
      fail_count++;
      summarize();
    end
    @(posedge pclk);
  endtask : wrel
  task key(input logic sh);
    shift_req <= sh;
    key_req <= 1'b1;
    @(posedge pclk);
    key_req <= 1'b0;
    shift_req <= 1'b0;
    @(posedge pclk);
  endtask : key
  // Read data is taken at the edge where pready is sampled high, as the master does.
  always @(posedge pclk) begin
    if (pready === 1'b1 && psel && penable && !pwrite) begin
      if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1FFFFFFFF);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    summarize();
  end
  initial begin
    cyc(8);
    presetn <= 1'b1;
    apb(0, REG_CTRL, 32'h0, 33'h1);
    apb(0, REG_LIM0, 32'h0, 33'h1);
    apb(0, REG_LIM1, 32'h0, 33'h1);
    apb(0, REG_GLIM, 32'h0, 33'hFFFF);
    apb(0, 8'h20, 32'h0, 33'h100000000);
    apb(1, REG_LIM0, 32'h64, 33'h0);
    apb(1, REG_LIM1, 32'h64, 33'h0);
    apb(0, REG_LIM1, 32'h0, 33'h64);
    repeat (20) begin
      torque0 <= 16'({$random(seed)} % 100);
      pclken <= 1'({$random(seed)} % 2);
      @(posedge pclk);
    end
    pclken <= 1'b1;
    fault <= 5'h01;
    cyc(10);
    chk(33'(relay_closed), 33'h1);
    fault <= 5'h00;
    torque0 <= 16'h006E;
    cyc(4);
    apb(0, REG_STAT, 32'h0, 33'h00010000);
    cyc(9850);
    chk(33'(relay_closed), 33'h1);
    wrel(1'b0);
    chk(33'(exc_cmd_out), 33'h3E8);
    apb(0, REG_STAT, 32'h0, 33'h00017001);
    cyc(5800);
    chk(33'(exc_cmd_out), 33'h3E8);
    cyc(400);
    chk(33'(exc_cmd_out), 33'h0);
    chk(33'(standby), 33'h0);
    torque0 <= 16'h0;
    key(1'b1);
    cyc(4);
    chk(33'(relay_closed), 33'h0);
    key(1'b0);
    wrel(1'b1);
    cyc(2);
    chk(33'(exc_cmd_out), 33'h3E8);
    torque1 <= 16'h0079;
    wrel(1'b0);
    cyc(2);
    chk(33'(msg_channel), 33'h1);
    chk(33'(alarm_msg), 33'(MSG_TORQUE));
    key(1'b0);
    cyc(4);
    chk(33'(relay_closed), 33'h0);
    torque1 <= 16'h0;
    key(1'b0);
    wrel(1'b1);
    apb(1, REG_CTRL, 32'h49, 33'h0);
    fault <= 5'h0C;
    wrel(1'b0);
    cyc(3);
    chk(33'(alarm_msg), 33'(MSG_TEMP));
    chk(33'(exc_cmd_out), 33'h64);
    fault <= 5'h1C;
    cyc(4);
    chk(33'(exc_cmd_out), 33'h0);
    chk(33'(alarm_msg), 33'(MSG_TEMP));
    key(1'b0);
    cyc(4);
    chk(33'(relay_closed), 33'h0);
    fault <= 5'h00;
    key(1'b0);
    wrel(1'b1);
    cyc(2);
    chk(33'(standby), 33'h1);
    cyc(2400);
    chk(33'(standby), 33'h0);
    apb(1, REG_CTRL, 32'h71, 33'h0);
    clutch_closed <= 1'b0;
    speed_zero <= 1'b1;
    cyc(3);
    chk(33'(clutch_ctrl), 33'h1);
    cyc(300);
    chk(33'(clutch_ctrl), 33'h0);
    wrel(1'b0);
    cyc(2);
    chk(33'(alarm_msg), 33'(MSG_CLUTCH));
    key(1'b0);
    cyc(4);
    chk(33'(relay_closed), 33'h0);
    clutch_closed <= 1'b1;
    speed_zero <= 1'b0;
    key(1'b0);
    wrel(1'b1);
    apb(1, REG_GLIM, 32'h64, 33'h0);
    torque0 <= 16'h0032;
    torque1 <= 16'h003C;
    wrel(1'b0);
    cyc(2);
    chk(33'(alarm_msg), 33'(MSG_GLOBAL));
    chk(33'(exc_cmd_out), 33'h3E8);
    torque0 <= 16'h0;
    torque1 <= 16'h0;
    key(1'b0);
    wrel(1'b1);
    summarize();
  end
endmodule : dyas_supervisor_tb
`default_nettype wire
